// ---- hw/jtag_prog_path.sv ----
// JTAG programming data path: TAP, programming data registers, reset control
//
// Behaviour
// - Port usable only with fuse and bit clear
// - External reset low clears disable bit, two clocks
// - Every shift register moves LSB first
// - Instruction register is four bits wide
// - Run-Test/Idle produces internal programming clocks
// - Opcode 0xC selects one-bit reset chain
// - Reset chain one holds device in reset
// - Reset time-out follows reset chain release
// - Opcode 0x4 loads and checks unlock key
// - Only signature A370 enables programming
// - Unlock key cleared on power-on reset
// - Opcode 0x5 captures result, shifts new command
// - Update applies command, idle clocks execute it
// - Opcode 0x6 shifts low command byte
// - Page load copies byte, writes within 11
// - Page load alternates low then high byte
// - Counter pre-increments before low bytes but first
// - Opcode 0x7 captures flash byte, low first
// - Counter post-increments after every high byte read
`timescale 1ns/100ps
`default_nettype none
`include "jtag_prog_params.svh"

module jtag_prog_path
  import jtag_prog_pkg::*;
#(
  parameter int CMD_W = `CMD_W,
  parameter int RESET_TIMEOUT_CYC = `RESET_TIMEOUT_CYC
) (
  // System clock and power-on reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Test access port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdoOeN,
  // Pins and fuse seen by the system side
  input wire logic tapAccessFuse,
  input wire logic extResetN,
  // Core control register disable bit, written by the core
  input wire logic ctrlWrEn,
  input wire logic ctrlWrData,
  output logic tapDisable,
  // Device reset outputs
  output logic resetChainOut,
  output logic coreResetN,
  // Flash interface, test clock domain
  input wire logic [CMD_W-1:0] cmdResult,
  input wire logic [`WORD_W-1:0] flashRdWord,
  output flash_req_s flashReq,
  output logic progMode
);

  // Elaboration checks on parameters
  generate
    if (CMD_W != `CMD_W) begin : g_bad_cmd_w
      $error("CMD_W must match the command register width");
    end
    if (RESET_TIMEOUT_CYC < 1) begin : g_bad_timeout
      $error("RESET_TIMEOUT_CYC must be at least one");
    end
  endgenerate

  localparam int TO_W = $clog2(RESET_TIMEOUT_CYC + 1);
  localparam int JTD_W = $clog2(`JTD_CLR_CYC + 1);

  // ---------------------------------------------------------------
  // System clock domain
  // ---------------------------------------------------------------

  // Three-stage synchronisers: fuse, external reset, reset chain
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;
  // Filtered values, updated only where stages two and three agree
  logic [2:0] filt_r;
  wire logic [2:0] filt_nxt;
  wire logic fuseOk;
  wire logic extRstLow;
  wire logic chainHeld;
  // Disable bit and its clear counter
  logic tapDisable_r;
  logic [JTD_W-1:0] jtdCnt_r;
  // Reset time-out counter and core reset output
  logic [TO_W-1:0] toCnt_r;
  logic coreResetN_r;
  logic tapEnable_r;
  wire logic rstHold;
  wire logic jtdClear;

  // A change is believed once the last two stages agree
  assign filt_nxt = (sync2_r & sync3_r) | (filt_r & (sync2_r | sync3_r));
  assign fuseOk = filt_r[0];
  assign extRstLow = ~filt_r[1];
  // Chain read from the filter's next value: saves one cycle of reset latency
  assign chainHeld = filt_nxt[2];

  // Synchroniser chain; stage one feeds stage two only
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= 3'h2;
      sync2_r <= 3'h2;
      sync3_r <= 3'h2;
      filt_r <= 3'h2;
    end else begin
      sync1_r <= {resetChainOut, extResetN, tapAccessFuse};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      filt_r <= filt_nxt;
    end
  end

  assign jtdClear = extRstLow && (jtdCnt_r == JTD_W'(`JTD_CLR_CYC - 1));

  // Disable bit: core writes it, a held external reset clears it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tapDisable_r <= 1'b0;
      jtdCnt_r <= '0;
    end else begin
      // Count system clocks while external reset stays low
      if (!extRstLow) begin
        jtdCnt_r <= '0;
      end else if (jtdCnt_r != JTD_W'(`JTD_CLR_CYC)) begin
        jtdCnt_r <= jtdCnt_r + JTD_W'(1);
      end
      if (jtdClear) begin
        tapDisable_r <= 1'b0;
      end else if (ctrlWrEn && !extRstLow) begin
        tapDisable_r <= ctrlWrData;
      end
    end
  end

  // Reset source: external pin low or a one in the reset chain
  assign rstHold = extRstLow || chainHeld;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      toCnt_r <= TO_W'(RESET_TIMEOUT_CYC);
      coreResetN_r <= 1'b0;
    end else begin
      if (rstHold) begin
        toCnt_r <= TO_W'(RESET_TIMEOUT_CYC);
      end else if (toCnt_r != '0) begin
        toCnt_r <= toCnt_r - TO_W'(1);
      end
      coreResetN_r <= !rstHold && (toCnt_r == '0);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tapEnable_r <= 1'b0;
    end else begin
      tapEnable_r <= fuseOk && !tapDisable_r;
    end
  end

  assign tapDisable = tapDisable_r;
  assign coreResetN = coreResetN_r;

  // ---------------------------------------------------------------
  // Test clock domain
  // ---------------------------------------------------------------

  // Enable level crossing into the test clock domain
  logic tapEnSync1_r;
  logic tapEnSync2_r;
  // TAP state and instruction registers
  tap_state_e state_r;
  tap_state_e state_nxt;
  logic [`IR_W-1:0] irShift_r;
  logic [`IR_W-1:0] ir_r;
  // Data registers
  logic chain_r;
  logic [`KEY_W-1:0] key_r;
  logic [CMD_W-1:0] cmd_r;
  logic bypass_r;
  logic progMode_r;
  // Page load and read sequencing
  logic pageHi_r;
  logic pageFirst_r;
  logic readHi_r;
  logic [`BYTE_W-1:0] tmp_r;
  logic tmpHigh_r;
  logic incrPend_r;
  logic [3:0] wrCnt_r;
  flash_req_s flashReq_r;
  // Pin outputs, updated on the falling test clock edge
  logic tdo_r;
  logic tdoOeN_r;

  // Two-stage crossing for the enable level
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      tapEnSync1_r <= 1'b0;
      tapEnSync2_r <= 1'b0;
    end else begin
      tapEnSync1_r <= tapEnable_r;
      tapEnSync2_r <= tapEnSync1_r;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_TLR: state_nxt = tms ? ST_TLR : ST_RTI;
      ST_RTI: state_nxt = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: state_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_nxt = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_nxt = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_nxt = tms ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: state_nxt = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_nxt = tms ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: state_nxt = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: state_nxt = tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: state_nxt = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_nxt = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_nxt = tms ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: state_nxt = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_nxt = tms ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: state_nxt = tms ? ST_SEL_DR : ST_RTI;
      default: state_nxt = ST_TLR;
    endcase
  end

  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_TLR;
    end else begin
      state_r <= tapEnSync2_r ? state_nxt : ST_TLR;
    end
  end

  // State decodes
  wire logic inCapDr = (state_r == ST_CAP_DR);
  wire logic inShiftDr = (state_r == ST_SHIFT_DR);
  wire logic inUpdDr = (state_r == ST_UPD_DR);
  wire logic inCapIr = (state_r == ST_CAP_IR);
  wire logic inShiftIr = (state_r == ST_SHIFT_IR);
  wire logic inUpdIr = (state_r == ST_UPD_IR);
  wire logic inRti = (state_r == ST_RTI);

  // Data register selection; flash paths only once unlocked
  wire logic selChain = (ir_r == `OP_RESET_CHAIN);
  wire logic selKey = (ir_r == `OP_UNLOCK);
  wire logic selCmd = (ir_r == `OP_COMMAND) && progMode_r;
  wire logic selLoad = (ir_r == `OP_PAGE_LOAD) && progMode_r;
  wire logic selRead = (ir_r == `OP_PAGE_READ) && progMode_r;
  wire logic selByte = selLoad || selRead;

  // Bit presented on the serial output during shifting
  wire logic drLsb = selChain ? chain_r :
                     selKey ? key_r[0] :
                     (selCmd || selByte) ? cmd_r[0] : bypass_r;
  wire logic [`BYTE_W-1:0] rdByte = readHi_r ? flashRdWord[15:8] : flashRdWord[7:0];

  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      irShift_r <= `IR_BYPASS;
      ir_r <= `IR_BYPASS;
    end else if (state_r == ST_TLR) begin
      ir_r <= `IR_BYPASS;
    end else if (inCapIr) begin
      irShift_r <= `IR_CAPTURE_VAL;
    end else if (inShiftIr) begin
      irShift_r <= {tdi, irShift_r[`IR_W-1:1]};
    end else if (inUpdIr) begin
      ir_r <= irShift_r;
    end
  end

  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      chain_r <= 1'b0;
      bypass_r <= 1'b0;
    end else if (inShiftDr && selChain) begin
      chain_r <= tdi;
    end else if (inShiftDr) begin
      bypass_r <= tdi;
    end else if (inCapDr) begin
      bypass_r <= 1'b0;
    end
  end

  assign resetChainOut = chain_r;

  // Unlock key register and programming mode flag
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      key_r <= `KEY_RESET;
      progMode_r <= 1'b0;
    end else if (inShiftDr && selKey) begin
      key_r <= {tdi, key_r[`KEY_W-1:1]};
    end else if (inUpdDr && selKey) begin
      progMode_r <= (key_r == `UNLOCK_SIGNATURE);
    end
  end

  // Command register; its low byte doubles as the data byte register
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      cmd_r <= '0;
    end else if (inCapDr && selCmd) begin
      cmd_r <= cmdResult;
    end else if (inShiftDr && selCmd) begin
      cmd_r <= {tdi, cmd_r[CMD_W-1:1]};
    end else if (inCapDr && selRead) begin
      cmd_r[7:0] <= rdByte;
    end else if (inShiftDr && selByte) begin
      cmd_r[7:0] <= {tdi, cmd_r[7:1]};
    end
  end

  // Byte alternation, restarted whenever a new instruction lands
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      pageHi_r <= 1'b0;
      pageFirst_r <= 1'b1;
      readHi_r <= 1'b0;
    end else if (inUpdIr) begin
      pageHi_r <= 1'b0;
      pageFirst_r <= 1'b1;
      readHi_r <= 1'b0;
    end else if (inUpdDr && selLoad) begin
      pageHi_r <= !pageHi_r;
      pageFirst_r <= 1'b0;
    end else if (inCapDr && selRead) begin
      readHi_r <= !readHi_r;
    end
  end

  // Page write sequencer: a later Update-DR restarts it, so the
  // programmer must leave the write time before the next byte
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      tmp_r <= '0;
      tmpHigh_r <= 1'b0;
      incrPend_r <= 1'b0;
      wrCnt_r <= '0;
    end else if (inUpdDr && selLoad) begin
      tmp_r <= cmd_r[7:0];
      tmpHigh_r <= pageHi_r;
      incrPend_r <= !pageHi_r && !pageFirst_r;
      wrCnt_r <= 4'(`PAGE_WR_DLY_TCK);
    end else if (wrCnt_r != '0) begin
      wrCnt_r <= wrCnt_r - 4'h1;
    end
  end

  // Flash request outputs; apply, pageWrite and pcIncr pulses last one test clock, exec stays high through Run-Test/Idle
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      flashReq_r <= '0;
    end else begin
      flashReq_r.apply <= 1'b0;
      flashReq_r.exec <= inRti && selCmd;
      flashReq_r.pcIncr <= ((wrCnt_r == 4'h2) && incrPend_r) ||
                           (inCapDr && selRead && readHi_r);
      flashReq_r.pageWrite <= (wrCnt_r == 4'h1);
      if (wrCnt_r == 4'h1) begin
        flashReq_r.pageData <= tmp_r;
        flashReq_r.pageHigh <= tmpHigh_r;
      end
      if (inUpdDr && selCmd) begin
        flashReq_r.cmd <= cmd_r;
        flashReq_r.apply <= 1'b1;
      end
    end
  end

  // Serial output changes on the falling edge, as the standard asks
  always_ff @(negedge tck or negedge rstn) begin
    if (!rstn) begin
      tdo_r <= 1'b0;
      tdoOeN_r <= 1'b1;
    end else begin
      tdo_r <= inShiftIr ? irShift_r[0] : drLsb;
      tdoOeN_r <= !(inShiftIr || inShiftDr);
    end
  end

  assign tdo = tdo_r;
  assign tdoOeN = tdoOeN_r;
  assign flashReq = flashReq_r;
  assign progMode = progMode_r;

endmodule

`default_nettype wire

// ---- hw/jtag_prog_params.svh ----
// Constants for the JTAG programming data path
`ifndef JTAG_PROG_PARAMS_SVH
`define JTAG_PROG_PARAMS_SVH

// Instruction register
`define IR_W 4
`define IR_CAPTURE_VAL 4'h1
`define IR_BYPASS 4'hF

// Instruction opcodes
`define OP_RESET_CHAIN 4'hC
`define OP_UNLOCK 4'h4
`define OP_COMMAND 4'h5
`define OP_PAGE_LOAD 4'h6
`define OP_PAGE_READ 4'h7

// Data register widths
`define CMD_W 15
`define KEY_W 16
`define BYTE_W 8
`define WORD_W 16

// Unlock signature and reset value of the key register
`define UNLOCK_SIGNATURE 16'hA370
`define KEY_RESET 16'h0000

// System clocks of external reset before the disable bit drops
`define JTD_CLR_CYC 2
// Latest test clock of a page buffer write after Update-DR
`define PAGE_WR_MAX_TCK 11
// Test clocks from Update-DR to the page buffer write strobe
`define PAGE_WR_DLY_TCK 2
// Default reset time-out in system clocks (fuse dependent)
`define RESET_TIMEOUT_CYC 16

`endif

// ---- hw/jtag_prog_pkg.sv ----
// Types shared by the JTAG programming data path
package jtag_prog_pkg;

  // TAP controller states, one-hot
  typedef enum logic [15:0] {
    ST_TLR = 16'h0001,
    ST_RTI = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SHIFT_DR = 16'h0010,
    ST_EXIT1_DR = 16'h0020,
    ST_PAUSE_DR = 16'h0040,
    ST_EXIT2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SHIFT_IR = 16'h0800,
    ST_EXIT1_IR = 16'h1000,
    ST_PAUSE_IR = 16'h2000,
    ST_EXIT2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } tap_state_e;

  // Requests toward the flash interface, all in the test clock domain
  typedef struct packed {
    logic [14:0] cmd;
    logic apply;
    logic exec;
    logic [7:0] pageData;
    logic pageHigh;
    logic pageWrite;
    logic pcIncr;
  } flash_req_s;

endpackage

// ---- dv/jtag_prog_monitor.sv ----
// Port checks for the JTAG programming data path
`timescale 1ns/100ps
`default_nettype none
module jtag_prog_monitor
  import jtag_prog_pkg::*;
#(
  parameter int CMD_W = 15,
  parameter int RESET_TIMEOUT_CYC = 16
) (
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic tck,
  // Test access port
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdoOeN,
  // System side
  input wire logic tapAccessFuse,
  input wire logic extResetN,
  input wire logic ctrlWrEn,
  input wire logic ctrlWrData,
  input wire logic tapDisable,
  input wire logic resetChainOut,
  input wire logic coreResetN,
  // Flash side
  input wire logic [CMD_W-1:0] cmdResult,
  input wire logic [15:0] flashRdWord,
  input wire flash_req_s flashReq,
  input wire logic progMode
);
  // Cycles spent in reset; saturates so a long hold cannot wrap
  logic [15:0] lowCnt_r;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lowCnt_r <= 16'h0000;
    end else if (coreResetN) begin
      lowCnt_r <= 16'h0000;
    end else if (lowCnt_r != 16'hFFFF) begin
      lowCnt_r <= lowCnt_r + 16'h0001;
    end
  end
  // Chain holds a one
  sequence chainHigh;
    resetChainOut;
  endsequence
  // Core reset follows within a few clocks
  sequence coreHeld;
    ##[0:4] !coreResetN;
  endsequence
  reset_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    chainHigh |-> coreHeld) else $error("core not held by chain");
  timeout_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(coreResetN) |-> lowCnt_r >= RESET_TIMEOUT_CYC) else $error("time-out cut short");
  jtd_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !extResetN [*8] |-> !tapDisable) else $error("disable bit not cleared");
  port_gate_a: assert property (@(posedge tck) disable iff (!rstn)
    (!tapAccessFuse || tapDisable) [*4] |-> tdoOeN) else $error("tdo driven while gated");
  locked_quiet_a: assert property (@(posedge tck) disable iff (!rstn)
    !progMode |-> !(flashReq.apply || flashReq.exec || flashReq.pageWrite))
    else $error("flash request while locked");
  apply_pulse_a: assert property (@(posedge tck) disable iff (!rstn)
    flashReq.apply |=> !flashReq.apply) else $error("apply longer than one clock");
  write_pulse_a: assert property (@(posedge tck) disable iff (!rstn)
    flashReq.pageWrite |=> !flashReq.pageWrite) else $error("write longer than one clock");
  incr_pulse_a: assert property (@(posedge tck) disable iff (!rstn)
    flashReq.pcIncr |=> !flashReq.pcIncr) else $error("counter step repeated");
  key_reset_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(rstn) |-> !progMode && !resetChainOut) else $error("state kept over reset");
endmodule
`default_nettype wire

// ---- dv/jtag_programmer.sv ----
// Programmer model driving the test access port
`timescale 1ns/100ps
`default_nettype none
module jtag_programmer (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // Clock parked low outside frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #80;
    q = tdo;
    tck = 1'b1;
    #80;
    tck = 1'b0;
  endtask
  // Clocks spent in Run-Test/Idle
  task automatic idle(input int n);
    logic q;
    repeat (n) step(1'b0, tdi, q);
  endtask
  task automatic goReset();
    logic q;
    repeat (5) step(1'b1, tdi, q);
    step(1'b0, tdi, q);
  endtask
  task automatic scan(input logic ir, input int n, input logic [15:0] din,
                      output logic [15:0] dout);
    logic q;
    dout = 16'h0000;
    step(1'b1, tdi, q);
    if (ir) begin
      step(1'b1, tdi, q);
    end
    step(1'b0, tdi, q);
    step(1'b0, tdi, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, tdi, q);
    step(1'b0, tdi, q);
    // Released data line must not look valid
    tdi = ~tdi;
  endtask
endmodule
`default_nettype wire

// ---- dv/jtag_prog_path_tb.sv ----
// Self-checking bench for the JTAG programming data path
`timescale 1ns/100ps
`default_nettype none
module jtag_prog_path_tb
  import jtag_prog_pkg::*;
();
  localparam int TO_CYC = 4; // Shortened reset time-out
  logic ref_clk = 1'b0, rstn = 1'b0, tapAccessFuse = 1'b1, extResetN = 1'b1;
  logic ctrlWrEn = 1'b0, ctrlWrData = 1'b0, oeSeen = 1'b0;
  logic [14:0] cmdResult = 15'h2A5C;
  logic [15:0] flashRdWord = 16'hBEEF, dout;
  logic [7:0] ld [3] = '{8'hA5, 8'h3C, 8'h96};
  logic [8:0] wrLog [$];
  wire logic tck, tms, tdi, tdo, tdoOeN, tapDisable, resetChainOut, coreResetN, progMode;
  wire flash_req_s flashReq;
  int fails = 0, n_tests = 0, cyc = 0, nExec = 0, nApply = 0, nIncr = 0;

  jtag_prog_path #(.RESET_TIMEOUT_CYC(TO_CYC)) uut (.ref_clk(ref_clk), .rstn(rstn),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOeN(tdoOeN),
    .tapAccessFuse(tapAccessFuse), .extResetN(extResetN), .ctrlWrEn(ctrlWrEn),
    .ctrlWrData(ctrlWrData), .tapDisable(tapDisable), .resetChainOut(resetChainOut),
    .coreResetN(coreResetN), .cmdResult(cmdResult), .flashRdWord(flashRdWord),
    .flashReq(flashReq), .progMode(progMode));
  jtag_programmer prog (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  // System clock
  always #12.5 ref_clk = ~ref_clk;
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      test_done();
    end
  end
  // Pulses are tck registers, so look half a period later
  always @(negedge tck) begin
    nExec += int'(flashReq.exec);
    nApply += int'(flashReq.apply);
    nIncr += int'(flashReq.pcIncr);
    if (flashReq.pageWrite === 1'b1) begin
      wrLog.push_back({flashReq.pageHigh, flashReq.pageData});
    end
  end
  // Enable moves on the falling edge, sample on the rising
  always @(posedge tck) begin
    if (tdoOeN === 1'b0) begin
      oeSeen = 1'b1;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic waitRef(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    waitRef(16);
    rstn = 1'b1;
    chk(progMode, 16'h0000);
    waitRef(40);
    chk(coreResetN, 16'h0001);
    // Chain set before programming
    prog.goReset();
    prog.scan(1'b1, 4, 16'h000C, dout);
    chk(dout, 16'h0001);
    prog.scan(1'b0, 1, 16'h0001, dout);
    waitRef(6);
    chk({resetChainOut, coreResetN}, 16'h0002);
    $display("test reset chain done");
    // Wrong key, then a locked command acts as bypass
    prog.scan(1'b1, 4, 16'h0004, dout);
    prog.scan(1'b0, 16, 16'hA371, dout);
    prog.idle(2);
    chk(progMode, 16'h0000);
    prog.scan(1'b1, 4, 16'h0005, dout);
    prog.scan(1'b0, 15, 16'h1357, dout);
    chk(dout, 16'h26AE);
    prog.scan(1'b1, 4, 16'h0004, dout);
    prog.scan(1'b0, 16, 16'hA370, dout);
    prog.idle(2);
    chk(progMode, 16'h0001);
    $display("test unlock done");
    // Command: result out, new command in, idle clocks execute
    prog.scan(1'b1, 4, 16'h0005, dout);
    nExec = 0;
    nApply = 0;
    prog.scan(1'b0, 15, 16'h1357, dout);
    chk(dout, 16'h2A5C);
    prog.idle(3);
    chk(flashReq.cmd, 16'h1357);
    chk(16'(nApply), 16'h0001);
    cmdResult = 15'h1B6D;
    prog.scan(1'b0, 15, 16'h0000, dout);
    chk(dout, 16'h1B6D);
    prog.scan(1'b1, 4, 16'h0006, dout);
    chk(16'(nExec), 16'h0006);
    $display("test command done");
    // Page load: low, high, low with one counter step
    nIncr = 0;
    for (int i = 0; i < 3; i++) begin
      prog.scan(1'b0, 8, {8'h00, ld[i]}, dout);
      prog.idle(11);
      chk(16'(wrLog.size()), 16'(i + 1));
      chk(16'(wrLog[i]), {7'h00, i[0], ld[i]});
    end
    chk(16'(nIncr), 16'h0001);
    $display("test page load done");
    // Page read: low, high, low; counter steps after the high byte
    prog.scan(1'b1, 4, 16'h0007, dout);
    nIncr = 0;
    for (int i = 0; i < 3; i++) begin
      if (i == 2) begin
        flashRdWord = 16'h5AC3;
      end
      prog.scan(1'b0, 8, 16'h0000, dout);
      chk(dout, (i == 2) ? 16'h00C3 : (i[0] ? 16'h00BE : 16'h00EF));
    end
    prog.idle(2);
    chk(16'(nIncr), 16'h0001);
    $display("test page read done");
    // Leave programming, then release the chain
    prog.scan(1'b1, 4, 16'h0004, dout);
    prog.scan(1'b0, 16, 16'h0000, dout);
    prog.idle(2);
    chk(progMode, 16'h0000);
    prog.scan(1'b1, 4, 16'h000C, dout);
    prog.scan(1'b0, 1, 16'h0000, dout);
    waitRef(40);
    chk({resetChainOut, coreResetN}, 16'h0001);
    $display("test release done");
    // Disable bit gates the port until the external reset clears it
    ctrlWrEn = 1'b1;
    ctrlWrData = 1'b1;
    waitRef(1);
    ctrlWrEn = 1'b0;
    waitRef(8);
    chk(tapDisable, 16'h0001);
    oeSeen = 1'b0;
    prog.scan(1'b1, 4, 16'h000C, dout);
    chk(oeSeen, 16'h0000);
    extResetN = 1'b0;
    waitRef(10);
    chk({tapDisable, coreResetN}, 16'h0000);
    extResetN = 1'b1;
    waitRef(40);
    prog.goReset();
    prog.scan(1'b1, 4, 16'h000C, dout);
    chk({oeSeen, dout[14:0]}, 16'h8001);
    tapAccessFuse = 1'b0;
    waitRef(10);
    oeSeen = 1'b0;
    prog.scan(1'b1, 4, 16'h000C, dout);
    chk(oeSeen, 16'h0000);
    $display("test port gating done");
    test_done();
  end
endmodule
bind jtag_prog_path jtag_prog_monitor #(.CMD_W(CMD_W),
  .RESET_TIMEOUT_CYC(RESET_TIMEOUT_CYC)) mon (.*);
`default_nettype wire
